// *** rtl/ipc_ctrl.sv ***
// interrupt controller: enables, flags, vectoring, sleep wake and pin change
//
// Summary of operation
// - every reset clears all interrupt enables.
// - take needs global enable, source enable, and peripheral enable for peripheral sources.
// - each flag sets on its event regardless of interrupt enables; a pin flag needs its edge detector enabled.
// - taking flushes prefetch, clears global enable, pushes PC, saves shadows, vectors 0004h.
// - with global enable clear, flags only; pending request taken once enabled again.
// - return pops address, restores shadows and sets global enable.
// - latency three or four cycles synchronous, three to five asynchronous.
// - external edge flag may set only in last or first quarter phase.
// - sleep with enabled pending flag and global enable clear acts as no-op.
// - request during or after sleep completes it, wakes, clears watchdog, marks timeout.
// - pin edges are detected even when pin-change master enable is clear.
// - each port pin has rise and fall detectors, separately enabled, both allowed.
// - enabled edge sets pin flag; request raised if master enable set.
// - summary flag is OR of pin flags and is read-only.
// - writing zero clears a pin flag; an edge during the write leaves it set.
// - pin change wakes from sleep when enabled; flags updated before wake.
`timescale 1ns/1ps
module ipc_ctrl
	import ipc_pkg::*;
#(
	parameter int PIN_W = 8
) (
	// clock, reset, enable
	input  wire logic              clk_sys_in,
	input  wire logic              reset_in,
	input  wire logic              ce_in,
	// register bus
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic      [31:0]       avs_readdata_out,
	output logic                   avs_waitrequest_out,
	// event sources
	input  wire logic              timer0_event_in,
	input  wire logic              ext_edge_pin_in,
	input  wire logic [7:0]        periph_one_event_in,
	input  wire logic [7:0]        periph_two_event_in,
	input  wire logic [PIN_W-1:0]  second_io_port_in,
	// core sequencer
	input  wire logic              core_return_from_interrupt_in,
	input  wire logic              core_sleep_in,
	output ipc_core_ev_type        core_ev_out,
	output logic      [14:0]       vector_addr_out,
	output logic                   irq_out
);

	ipc_state_type    r;
	ipc_state_type    next_r;
	logic [PIN_W-1:0] pin_flags;
	logic             pin_edge;
	logic             pin_summary;
	logic             pending;
	logic             wr_hit;
	logic             ext_det;
	logic [7:0]       rd_mux;

	// ======================================================================
	// helpers
	// one enabled-and-flagged term, shared by both peripheral banks
	function automatic logic ipc_any_pair(input logic [7:0] en, input logic [7:0] fl);
		ipc_any_pair = |(en & fl);
	endfunction : ipc_any_pair

	// pin change unit
	ipc_pin_change #(
		.WIDTH(PIN_W)
	) u_pin_change (
		.clk_sys_in (clk_sys_in),
		.reset_in   (reset_in),
		.ce_in      (ce_in),
		.pins_in    (second_io_port_in),
		.rise_en_in (r.rise_en[PIN_W-1:0]),
		.fall_en_in (r.fall_en[PIN_W-1:0]),
		.wr_in      (wr_hit && avs_address_in == OFS_PIN_FLAGS && avs_byteenable_in[0]),
		.wdata_in   (avs_writedata_in[PIN_W-1:0]),
		.flags_out  (pin_flags),
		.edge_out   (pin_edge)
	);

	// ======================================================================
	// request formation
	// summary flag has no storage, so software cannot write it
	assign pin_summary = |pin_flags;
	assign pending = (r.icon.timer0_int_enable && r.icon.timer0_flag)
		|| (r.icon.ext_edge_enable && r.icon.ext_edge_flag)
		|| (r.icon.pin_change_master_enable && pin_summary)
		|| (r.icon.peripheral_int_enable
			&& (ipc_any_pair(r.pen_one, r.pfl_one) || ipc_any_pair(r.pen_two, r.pfl_two)));
	assign wr_hit = avs_write_in && r.ack;
	assign ext_det = ext_edge_pin_in && !r.ext_prev;

	// read multiplexer, unmapped offsets read zero
	always_comb begin
		rd_mux = 8'h00;
		case (avs_address_in)
			OFS_ICON:        rd_mux = {r.icon, pin_summary};
			OFS_PIN_FLAGS:   rd_mux = 8'(pin_flags);
			OFS_FALL_EN:     rd_mux = r.fall_en;
			OFS_RISE_EN:     rd_mux = r.rise_en;
			OFS_PEN_ONE:     rd_mux = r.pen_one;
			OFS_PEN_TWO:     rd_mux = r.pen_two;
			OFS_PFL_ONE:     rd_mux = r.pfl_one;
			OFS_PFL_TWO:     rd_mux = r.pfl_two;
			OFS_IRQ_STATUS:  rd_mux = {4'h0, r.ist};
			OFS_IRQ_ENABLE:  rd_mux = {4'h0, r.ien};
			OFS_CORE_STATUS: rd_mux = {4'h0, r.ev.asleep, r.icon.global_int_enable, 2'(r.core)};
			default:         rd_mux = 8'h00;
		endcase
	end

	// ======================================================================
	// next state
	always_comb begin
		next_r = r;
		if (ce_in) begin
			next_r.q = r.q + Q_STEP;
			next_r.ev.flush = 1'b0;
			next_r.ev.take = 1'b0;
			next_r.ev.restore = 1'b0;
			next_r.ev.sleep_nop = 1'b0;
			next_r.ev.wake = 1'b0;

			// bus slave: one wait cycle, write lands on the edge that sees waitrequest low
			next_r.ack = (avs_read_in || avs_write_in) && !r.ack;
			next_r.rdata = rd_mux;
			if (wr_hit && avs_byteenable_in[0]) begin
				case (avs_address_in)
					OFS_ICON:       next_r.icon = ipc_icon_type'(avs_writedata_in[7:1]);
					OFS_FALL_EN:    next_r.fall_en = avs_writedata_in[7:0];
					OFS_RISE_EN:    next_r.rise_en = avs_writedata_in[7:0];
					OFS_PEN_ONE:    next_r.pen_one = avs_writedata_in[7:0] & PFL_ONE_IMPL;
					OFS_PEN_TWO:    next_r.pen_two = avs_writedata_in[7:0] & PFL_TWO_IMPL;
					OFS_PFL_ONE:    next_r.pfl_one = avs_writedata_in[7:0] & PFL_ONE_IMPL;
					OFS_PFL_TWO:    next_r.pfl_two = avs_writedata_in[7:0] & PFL_TWO_IMPL;
					OFS_IRQ_ENABLE: next_r.ien = avs_writedata_in[ST_W-1:0];
					OFS_IRQ_CLEAR:  next_r.ist = r.ist & ~avs_writedata_in[ST_W-1:0];
					default:        next_r.ien = next_r.ien;
				endcase
			end

			// flags set regardless of enables, and after the write so the set wins
			next_r.icon.timer0_flag = next_r.icon.timer0_flag | timer0_event_in;
			next_r.pfl_one = next_r.pfl_one | (periph_one_event_in & PFL_ONE_IMPL);
			next_r.pfl_two = next_r.pfl_two | (periph_two_event_in & PFL_TWO_IMPL);

			// asynchronous pin edge held until the Q4/Q1 window opens
			next_r.ext_prev = ext_edge_pin_in;
			if (r.q == Q_LAST || r.q == Q_FIRST) begin
				next_r.icon.ext_edge_flag = next_r.icon.ext_edge_flag | ext_det | r.ext_pend;
				next_r.ext_pend = 1'b0;
			end else begin
				next_r.ext_pend = r.ext_pend | ext_det;
			end

			// vectoring sequence, advanced on instruction cycle boundaries
			case (r.core)
				C_IDLE: begin
					// a disabled request simply waits here until enabled again
					if (r.q == Q_LAST && r.icon.global_int_enable && pending) begin
						next_r.core = C_FLUSH;
						next_r.icon.global_int_enable = 1'b0;
						next_r.ev.flush = 1'b1;
					end
				end
				C_FLUSH: begin
					if (r.q == Q_LAST) begin
						next_r.core = C_PUSH;
					end
				end
				C_PUSH: begin
					if (r.q == Q_LAST) begin
						next_r.core = C_IDLE;
						next_r.ev.take = 1'b1; // push PC, save shadows, load vector
						next_r.vec = VECTOR_ADDR;
						next_r.ist[ST_TAKE] = 1'b1;
					end
				end
				default: begin
					next_r.core = C_IDLE;
				end
			endcase

			// return restores context and re-opens interrupts
			if (core_return_from_interrupt_in) begin
				next_r.icon.global_int_enable = 1'b1;
				next_r.ev.restore = 1'b1;
			end

			// sleep handling while a request may already stand
			if (core_sleep_in && !r.ev.asleep) begin
				if (!r.icon.global_int_enable && pending) begin
					next_r.ev.sleep_nop = 1'b1; // watchdog and power flags left alone
					next_r.ist[ST_NOP] = 1'b1;
				end else begin
					next_r.ev.asleep = 1'b1;
				end
			end
			if (r.ev.asleep && pending) begin
				next_r.ev.asleep = 1'b0;
				next_r.ev.wake = 1'b1; // clear watchdog, set timeout, clear power-down
				next_r.ist[ST_WAKE] = 1'b1;
			end
			if (pin_edge) begin
				next_r.ist[ST_PIN] = 1'b1;
			end
			next_r.irq = |(r.ist & r.ien);
		end
	end

	// ======================================================================
	// state register: every reset clears all enables
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from the state register
	assign avs_readdata_out = {24'h000000, r.rdata};
	assign avs_waitrequest_out = !r.ack;
	assign core_ev_out = r.ev;
	assign vector_addr_out = r.vec;
	assign irq_out = r.irq;

	// ======================================================================
	// checks
	sequence s_flush_run;
		(core_ev_out.flush && ce_in) ##1 ce_in[*7];
	endsequence

	a_reset_no_enable: assert property (@(posedge clk_sys_in)
		$fell(reset_in) |-> (r.icon == '0 && r.pen_one == RST_BYTE && r.pen_two == RST_BYTE))
		else $error("enables not clear after reset");
	a_take_needs_enables: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && r.core == C_IDLE && next_r.core == C_FLUSH) |-> (r.icon.global_int_enable && pending))
		else $error("interrupt taken without enables");
	a_flag_sets_always: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && periph_one_event_in[0]) |=> r.pfl_one[0])
		else $error("peripheral flag missed its event");
	a_vector_take: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		core_ev_out.take |-> (vector_addr_out == VECTOR_ADDR && $past(r.core) == C_PUSH))
		else $error("vector taken with wrong address or sequence");
	a_flush_clears_enable: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		core_ev_out.flush |-> !r.icon.global_int_enable)
		else $error("global enable still set after flush");
	a_hold_when_off: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && !r.icon.global_int_enable && r.core == C_IDLE) |=> r.core == C_IDLE)
		else $error("redirected with global enable clear");
	a_return_sets_enable: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && core_return_from_interrupt_in) |=> (r.icon.global_int_enable && core_ev_out.restore))
		else $error("return did not set global enable");
	a_vector_latency: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		s_flush_run |=> core_ev_out.take)
		else $error("vector not reached eight cycles after flush");
	a_ext_window: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		$rose(r.icon.ext_edge_flag) |-> (r.q == 2'h0 || r.q == 2'h1))
		else $error("external edge flag set outside the Q4/Q1 window");
	a_sleep_as_nop: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && core_sleep_in && !r.ev.asleep && !r.icon.global_int_enable && pending)
		|=> (core_ev_out.sleep_nop && !core_ev_out.asleep && !core_ev_out.wake))
		else $error("sleep with pending request was not a no-op");
	a_wake_at_once: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && r.ev.asleep && pending) |=> (core_ev_out.wake && !core_ev_out.asleep))
		else $error("no immediate wake on enabled request");
	a_summary_or: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(r.ack && avs_read_in && $past(avs_address_in) == OFS_ICON && $past(ce_in))
		|-> (avs_readdata_out[0] == $past(pin_summary)))
		else $error("summary flag differs from pin flags");

endmodule : ipc_ctrl

// *** common/ipc_pkg.sv ***
// shared constants and types for the interrupt and pin-change controller
package ipc_pkg;

	// ======================================================================
	// register map (byte addresses, one 32-bit word each)
	localparam int          ADDR_W          = 6;
	localparam logic [5:0]  OFS_ICON        = 6'h00;
	localparam logic [5:0]  OFS_PIN_FLAGS   = 6'h04;
	localparam logic [5:0]  OFS_FALL_EN     = 6'h08;
	localparam logic [5:0]  OFS_RISE_EN     = 6'h0C;
	localparam logic [5:0]  OFS_PEN_ONE     = 6'h10;
	localparam logic [5:0]  OFS_PEN_TWO     = 6'h14;
	localparam logic [5:0]  OFS_PFL_ONE     = 6'h18;
	localparam logic [5:0]  OFS_PFL_TWO     = 6'h1C;
	localparam logic [5:0]  OFS_IRQ_STATUS  = 6'h20;
	localparam logic [5:0]  OFS_IRQ_ENABLE  = 6'h24;
	localparam logic [5:0]  OFS_IRQ_CLEAR   = 6'h28;
	localparam logic [5:0]  OFS_CORE_STATUS = 6'h2C;

	// ======================================================================
	// reset values and implemented bits
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [3:0]  RST_NIBBLE      = 4'h0;
	localparam logic [7:0]  PFL_ONE_IMPL    = 8'hC1;
	localparam logic [7:0]  PFL_TWO_IMPL    = 8'h04;
	localparam logic [14:0] VECTOR_ADDR     = 15'h0004;

	// ======================================================================
	// instruction cycle phases: four system clocks per instruction cycle
	localparam logic [1:0]  Q_FIRST         = 2'h0;
	localparam logic [1:0]  Q_LAST          = 2'h3;
	localparam logic [1:0]  Q_STEP          = 2'h1;

	// ======================================================================
	// sticky status bit positions of the system interrupt
	localparam int          ST_TAKE         = 0;
	localparam int          ST_WAKE         = 1;
	localparam int          ST_NOP          = 2;
	localparam int          ST_PIN          = 3;
	localparam int          ST_W            = 4;

	// ======================================================================
	// types
	typedef enum logic [1:0] {C_IDLE, C_FLUSH, C_PUSH} ipc_core_type;

	typedef struct packed {
		logic global_int_enable;
		logic peripheral_int_enable;
		logic timer0_int_enable;
		logic ext_edge_enable;
		logic pin_change_master_enable;
		logic timer0_flag;
		logic ext_edge_flag;
	} ipc_icon_type;

	typedef struct packed {
		logic flush;
		logic take;
		logic restore;
		logic sleep_nop;
		logic wake;
		logic asleep;
	} ipc_core_ev_type;

	typedef struct packed {
		ipc_icon_type    icon;
		logic [7:0]      pfl_one;
		logic [7:0]      pfl_two;
		logic [7:0]      pen_one;
		logic [7:0]      pen_two;
		logic [7:0]      rise_en;
		logic [7:0]      fall_en;
		ipc_core_type    core;
		logic [1:0]      q;
		logic            ext_prev;
		logic            ext_pend;
		logic            ack;
		logic [7:0]      rdata;
		logic [ST_W-1:0] ist;
		logic [ST_W-1:0] ien;
		ipc_core_ev_type ev;
		logic [14:0]     vec;
		logic            irq;
	} ipc_state_type;

endpackage : ipc_pkg

// *** rtl/ipc_pin_change.sv ***
// per-pin rising and falling edge detectors with sticky change flags
`timescale 1ns/1ps
module ipc_pin_change
	import ipc_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock, reset, enable
	input  wire logic             clk_sys_in,
	input  wire logic             reset_in,
	input  wire logic             ce_in,
	// pins and detector enables
	input  wire logic [WIDTH-1:0] pins_in,
	input  wire logic [WIDTH-1:0] rise_en_in,
	input  wire logic [WIDTH-1:0] fall_en_in,
	// software write of the flags
	input  wire logic             wr_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	// flags and edge pulse
	output logic      [WIDTH-1:0] flags_out,
	output logic                  edge_out
);

	typedef struct packed {
		logic [WIDTH-1:0] prev;
		logic             primed;
		logic [WIDTH-1:0] flags;
		logic             edge_seen;
	} ipc_pin_state_type;

	ipc_pin_state_type r;
	ipc_pin_state_type next_r;
	logic [WIDTH-1:0]  edges;

	// ======================================================================
	// edge detection runs whatever the master enable says
	always_comb begin
		next_r = r;
		edges = (r.primed) ? ((pins_in & ~r.prev & rise_en_in) | (~pins_in & r.prev & fall_en_in)) : '0;
		if (ce_in) begin
			next_r.prev = pins_in;
			next_r.primed = 1'b1; // first sample only primes, no false edge out of reset
			if (wr_in) begin
				next_r.flags = wdata_in;
			end
			next_r.flags = next_r.flags | edges; // new edge beats the clearing write
			next_r.edge_seen = |edges;
		end
	end

	// state register
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign flags_out = r.flags;
	assign edge_out = r.edge_seen;

	// ======================================================================
	// checks
	a_edge_flags_pin: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && r.primed && pins_in[0] && !r.prev[0] && rise_en_in[0]) |=> r.flags[0])
		else $error("rising edge on pin 0 did not set its flag");
	a_clear_loses_none: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		(ce_in && wr_in && edges[0]) |=> (r.flags[0] && r.edge_seen))
		else $error("edge during clearing write was lost");

endmodule : ipc_pin_change

// *** bench/ipc_core_model.sv ***
// partner model: core sequencer that services takes, returns and issues sleep
`timescale 1ns/1ps
module ipc_core_model
	import ipc_pkg::*;
(
	// clock and reset
	input  wire logic            clk_sys_in,
	input  wire logic            reset_in,
	// controller side
	input  wire ipc_core_ev_type core_ev_in,
	output logic                 ret_out,
	output logic                 sleep_out,
	// bench side
	input  wire logic            sleep_req_in,
	input  wire logic [7:0]      ret_delay_in,
	output int                   take_cnt_out,
	output int                   wake_cnt_out,
	output int                   nop_cnt_out,
	output int                   gap_out
);
	int ret_wait;
	int gap_run;

	// ======================================================================
	// service routine runs for a programmable time, which the bench fixes at 3Ch cycles
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ret_out      <= 1'b0;
			sleep_out    <= 1'b0;
			take_cnt_out <= 0;
			wake_cnt_out <= 0;
			nop_cnt_out  <= 0;
			gap_out      <= 0;
			ret_wait     <= 0;
			gap_run      <= 0;
		end else begin
			ret_out   <= 1'b0;
			sleep_out <= sleep_req_in; // one pulse per request
			gap_run   <= core_ev_in.flush ? 1 : gap_run + 1;
			if (core_ev_in.take) begin
				take_cnt_out <= take_cnt_out + 1; // pc pushed, jump to vector
				gap_out      <= gap_run;
				ret_wait     <= int'(ret_delay_in);
			end else if (ret_wait == 1) begin
				ret_out  <= 1'b1; // return pops pc and restores context
				ret_wait <= 0;
			end else if (ret_wait > 1) begin
				ret_wait <= ret_wait - 1;
			end
			if (core_ev_in.wake) begin
				wake_cnt_out <= wake_cnt_out + 1;
			end
			if (core_ev_in.sleep_nop) begin
				nop_cnt_out <= nop_cnt_out + 1;
			end
		end
	end
endmodule : ipc_core_model

// *** bench/testbench.sv ***
// self-checking bench for the interrupt and pin-change controller
`timescale 1ns/1ps
module testbench
	import ipc_pkg::*;
;
	// ======================================================================
	// stimulus and observed signals
	logic            clk_sys_in, reset_in, rd, wr, t0_ev, ext_pin, sleep_req, wait_rq, ret, slp, irq, ce;
	logic [5:0]      addr;
	logic [31:0]     wdata, rdata;
	logic [7:0]      p1_ev, p2_ev, port, rv;
	logic [14:0]     vec;
	ipc_core_ev_type ev;
	int              take_cnt, wake_cnt, nop_cnt, gap, err_total, cmp_count;

	// ======================================================================
	// clock, design and partner
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end

	ipc_ctrl #(.PIN_W(8)) dut (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_rq),
		.timer0_event_in(t0_ev), .ext_edge_pin_in(ext_pin), .periph_one_event_in(p1_ev),
		.periph_two_event_in(p2_ev), .second_io_port_in(port),
		.core_return_from_interrupt_in(ret), .core_sleep_in(slp),
		.core_ev_out(ev), .vector_addr_out(vec), .irq_out(irq));

	ipc_core_model core (
		.clk_sys_in(clk_sys_in), .reset_in(reset_in), .core_ev_in(ev), .ret_out(ret), .sleep_out(slp),
		.sleep_req_in(sleep_req), .ret_delay_in(8'h3C), .take_cnt_out(take_cnt),
		.wake_cnt_out(wake_cnt), .nop_cnt_out(nop_cnt), .gap_out(gap));

	// ======================================================================
	// compare, bus access and waiting helpers
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		addr  <= a;
		wdata <= {24'h000000, d};
		rd    <= ~w;
		wr    <= w;
		@(posedge clk_sys_in);
		while (wait_rq !== 1'b0 && n < 50) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n == 50) err_total++;
		rv = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(nm, {24'h000000, rv}, {24'h000000, e});
	endtask : rd_chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_in);
	endtask : tick

	// bounded wait for the partner to count the k-th take
	task automatic wait_take(input int k);
		int n;
		n = 0;
		while (take_cnt < k && n < 300) begin
			@(posedge clk_sys_in);
			n++;
		end
		if (n == 300) err_total++;
	endtask : wait_take

	task automatic pulse_sleep();
		@(posedge clk_sys_in);
		sleep_req <= 1'b1;
		@(posedge clk_sys_in);
		sleep_req <= 1'b0;
	endtask : pulse_sleep

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_sim

	// ======================================================================
	// watchdog: the sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		err_total++;
		end_sim();
	end

	// ======================================================================
	// main sequence
	initial begin
		{reset_in, ce, rd, wr, t0_ev, ext_pin, sleep_req} = 7'b1100000;
		{addr, wdata, p1_ev, p2_ev, port} = '0;
		err_total = 0;
		cmp_count = 0;
		tick(3);
		reset_in <= 1'b0;
		rd_chk("icon_rst", OFS_ICON, 8'h00);
		rd_chk("pen_rst", OFS_PEN_ONE, 8'h00);
		rd_chk("unmapped", 6'h30, 8'h00);
		// flag sets with every enable off
		@(posedge clk_sys_in);
		t0_ev <= 1'b1;
		@(posedge clk_sys_in);
		t0_ev <= 1'b0;
		tick(40);
		rd_chk("icon_flag", OFS_ICON, 8'h04);
		chk("no_take", take_cnt, 0);
		// enable: pending flag is taken, then taken again while not cleared
		bus(1'b1, OFS_ICON, 8'hA4);
		wait_take(1);
		chk("vector", {17'h0, vec}, 32'h0004);
		chk("latency", gap, 8);
		rd_chk("gie_off", OFS_ICON, 8'h24);
		wait_take(2); // flag left set gives a second entry
		bus(1'b1, OFS_ICON, 8'h20); // service clears its flag
		tick(150);
		chk("take_twice", take_cnt, 2);
		rd_chk("gie_back", OFS_ICON, 8'hA0);
		// peripheral source needs the peripheral enable as well
		bus(1'b1, OFS_ICON, 8'h80);
		bus(1'b1, OFS_PEN_ONE, 8'h01);
		@(posedge clk_sys_in);
		p1_ev <= 8'h01;
		@(posedge clk_sys_in);
		p1_ev <= 8'h00;
		tick(60);
		chk("pe_gate", take_cnt, 2);
		rd_chk("pfl_one", OFS_PFL_ONE, 8'h01);
		bus(1'b1, OFS_ICON, 8'hC0);
		wait_take(3);
		chk("pe_take", take_cnt, 3);
		bus(1'b1, OFS_PFL_ONE, 8'h00);
		tick(100);
		// system interrupt: masked, raised, cleared
		rd_chk("ist", OFS_IRQ_STATUS, 8'h01);
		chk("irq_mask", irq, 1'b0);
		bus(1'b1, OFS_IRQ_ENABLE, 8'h01);
		tick(3);
		chk("irq_on", irq, 1'b1);
		bus(1'b1, OFS_IRQ_CLEAR, 8'h01);
		tick(3);
		chk("irq_off", irq, 1'b0);
		rd_chk("ist_clr", OFS_IRQ_STATUS, 8'h00);
		// pin change with master enable off
		bus(1'b1, OFS_ICON, 8'h00);
		bus(1'b1, OFS_RISE_EN, 8'h01);
		bus(1'b1, OFS_FALL_EN, 8'h03);
		port <= 8'h01;
		tick(4);
		rd_chk("pin_rise", OFS_PIN_FLAGS, 8'h01);
		rd_chk("summary", OFS_ICON, 8'h01);
		port <= 8'h03;
		tick(4);
		port <= 8'h01;
		tick(4);
		rd_chk("pin_fall", OFS_PIN_FLAGS, 8'h03);
		bus(1'b1, OFS_PIN_FLAGS, 8'h03 & ~8'h03); // writes zero to all flag bits, clearing every pin flag
		rd_chk("pin_clr", OFS_PIN_FLAGS, 8'h00);
		bus(1'b1, OFS_ICON, 8'h01);
		rd_chk("summary_ro", OFS_ICON, 8'h00);
		// sleep with an enabled pending flag and global enable clear
		@(posedge clk_sys_in);
		t0_ev <= 1'b1;
		@(posedge clk_sys_in);
		t0_ev <= 1'b0;
		bus(1'b1, OFS_ICON, 8'h24);
		pulse_sleep();
		tick(4);
		chk("sleep_nop", nop_cnt, 1);
		chk("no_wake", wake_cnt, 0);
		// real sleep, woken by a pin edge
		bus(1'b1, OFS_ICON, 8'h08);
		pulse_sleep();
		tick(4);
		chk("asleep", ev.asleep, 1'b1);
		port <= 8'h00;
		tick(6);
		chk("wake", wake_cnt, 1);
		rd_chk("pin_wake", OFS_PIN_FLAGS, 8'h01);
		// rising pin 0 lands on the very edge of the clearing write
		fork
			bus(1'b1, OFS_PIN_FLAGS, 8'h00);
			begin
				tick(2);
				port <= 8'h01;
			end
		join
		rd_chk("pin_race", OFS_PIN_FLAGS, 8'h01);
		// external edge flag
		ext_pin <= 1'b1;
		tick(8);
		rd_chk("ext_flag", OFS_ICON, 8'h0B);
		// frozen while the clock enable is low: the timer event is not seen
		@(posedge clk_sys_in);
		ce    <= 1'b0;
		t0_ev <= 1'b1;
		tick(4);
		ce    <= 1'b1;
		t0_ev <= 1'b0;
		rd_chk("ce_freeze", OFS_ICON, 8'h0B);
		// reset in mid-run clears every enable; pin back to idle so no false edge follows
		reset_in <= 1'b1;
		ext_pin  <= 1'b0;
		tick(3);
		reset_in <= 1'b0;
		rd_chk("icon_rst2", OFS_ICON, 8'h00);
		rd_chk("rise_rst2", OFS_RISE_EN, 8'h00);
		chk("irq_rst2", irq, 1'b0);
		end_sim();
	end
endmodule : testbench
